// ===== dcl_chk.sv
/*
  checker for the command limiter: apb handshake and motor gating.
  assumes it is bound onto dcl_limiter with one pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dcl_chk
  import dcl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic run_cmd,
  input wire logic signed [FW-1:0] freq_out,
  input wire logic motor_enable,
  input wire logic restriction_display,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // phases of one apb transfer
  sequence s_setup; psel && !penable && ce; endsequence
  sequence s_done; psel && penable && pready; endsequence
  // properties on handshake and motor gating
  property p_ready_one; s_setup |=> s_done; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_ready_access; pready |-> psel && penable; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_norun; !run_cmd && ce |=> !motor_enable; endproperty
  property p_block; restriction_display |-> !motor_enable; endproperty
  property p_freeze;
    !ce |=> $stable(motor_enable) && $stable(freq_out);
  endproperty
  property p_rst; $rose(presetn) |-> !motor_enable && !irq; endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("no answer one cycle after setup");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held over two cycles");
  a_ready_access: assert property (p_ready_access)
    else $error("pready outside access phase");
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  a_norun: assert property (p_norun)
    else $error("motor enabled without run command");
  a_block: assert property (p_block)
    else $error("motor runs while restriction shown");
  a_freeze: assert property (p_freeze)
    else $error("outputs moved with clock enable low");
  a_rst: assert property (p_rst)
    else $error("outputs active after reset");
endmodule : dcl_chk
bind dcl_limiter dcl_chk i_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .run_cmd(run_cmd), .freq_out(freq_out), .motor_enable(motor_enable),
  .restriction_display(restriction_display), .irq(irq)
);
`default_nettype wire

// ===== dcl_ctl_model.sv
/*
  model of the machine control system driving the limiter pins.
  assumes requests from the bench; all pins change after pclk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module dcl_ctl_model
  import dcl_pkg::*;
#(parameter int PERMIT_TERM = 2)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic permit,
  input wire logic motor2,
  input wire logic run,
  input wire logic rev,
  input wire logic jog,
  input wire logic signed [FW-1:0] freq,
  input wire logic signed [FW-1:0] est,
  output logic [NTERM-1:0] input_terminal_pins,
  output logic second_motor_pin,
  output logic run_cmd,
  output logic run_rev,
  output logic jog_sel,
  output logic signed [FW-1:0] base_frequency_command,
  output logic signed [FW-1:0] rotation_estimate
);
  localparam logic [NTERM-1:0] PMASK = NTERM'(1) << PERMIT_TERM;
  logic [NTERM-1:0] noise;
  // spare terminals chatter; only the permit terminal means anything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noise <= 7'h55;
      input_terminal_pins <= 7'h00;
      second_motor_pin <= 1'h0;
      run_cmd <= 1'h0;
      run_rev <= 1'h0;
      jog_sel <= 1'h0;
      base_frequency_command <= 16'h0000;
      rotation_estimate <= 16'h0000;
    end else begin
      noise <= ~noise;
      input_terminal_pins <= (noise & ~PMASK) | (permit ? PMASK : '0);
      second_motor_pin <= motor2;
      run_cmd <= run;
      run_rev <= rev;
      jog_sel <= jog;
      base_frequency_command <= freq;
      rotation_estimate <= est;
    end
  end
endmodule : dcl_ctl_model
`default_nettype wire

// ===== dcl_limit_bank.sv
/*
  two copies of the upper and lower limits, selected by motor set.
  assumes writes arrive already validated on the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dcl_limit_bank
  import dcl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic wr_set,
  input wire logic wr_upper,
  input wire logic [FW-1:0] wr_data,
  input wire logic rd_set,
  output logic [FW-1:0] upper,
  output logic [FW-1:0] lower
);
  logic [FW-1:0] up_mem [2];
  logic [FW-1:0] lo_mem [2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_mem[0] <= RST_LIMIT;
      up_mem[1] <= RST_LIMIT;
      lo_mem[0] <= RST_LIMIT;
      lo_mem[1] <= RST_LIMIT;
    end else if (ce && wr_en) begin
      if (wr_upper) begin
        up_mem[wr_set] <= wr_data;
      end else begin
        lo_mem[wr_set] <= wr_data;
      end
    end
  end

  // registered read of the selected set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper <= RST_LIMIT;
      lower <= RST_LIMIT;
    end else if (ce) begin
      upper <= up_mem[rd_set];
      lower <= lo_mem[rd_set];
    end
  end
endmodule : dcl_limit_bank
`default_nettype wire

// ===== dcl_limiter.sv
/*
  drive command limiter: clamps the signed frequency command, applies
  direction restriction, reversal protection (in MODE_SLV only) and run permission.
  assumes apb master on pclk; terminal and motor-select pins asynchronous;
  frequency command and rotation estimate synchronous to pclk.
*/
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcl_limiter
  import dcl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NTERM-1:0] input_terminal_pins,
  input wire logic second_motor_pin,
  input wire logic run_cmd,
  input wire logic run_rev,
  input wire logic jog_sel,
  input wire logic signed [FW-1:0] base_frequency_command,
  input wire logic signed [FW-1:0] rotation_estimate,
  output logic signed [FW-1:0] freq_out,
  output logic motor_enable,
  output logic restriction_display,
  output logic limit_warning,
  output logic irq
);
  // configuration registers and status
  logic [1:0] run_direction_restriction;
  logic [1:0] reversal_protection_select;
  logic [1:0] control_mode_select;
  logic [FW-1:0] jog_frequency_setting;
  logic [FW-1:0] max_freq;
  logic [FW-1:0] min_freq;
  logic [6:0] term_fn [NTERM];
  logic [NST-1:0] status;
  logic [NST-1:0] mask;

  // synchroniser stages for the asynchronous pins
  logic [NTERM-1:0] term_s1;
  logic [NTERM-1:0] term_s2;
  logic sm_s1;
  logic sm_s2;

  // limit bank outputs, write decode and shadows
  logic [FW-1:0] upper_frequency_limit;
  logic [FW-1:0] lower_frequency_limit;
  logic [FW-1:0] lim_wdata;
  logic lim_wr;
  logic lim_set;
  logic lim_upper;
  logic [FW-1:0] peer_up;
  logic [FW-1:0] peer_lo;
  logic [FW-1:0] up1_shadow;
  logic [FW-1:0] lo1_shadow;
  logic [FW-1:0] up2_shadow;
  logic [FW-1:0] lo2_shadow;

  // bus decode
  logic wr_ok;
  logic access;

  // permission, direction and command path
  logic [NTERM-1:0] permit_hit;
  logic permit_assigned;
  logic permit_on;
  logic permit_d;
  logic want_rev;
  logic blocked;
  logic running;
  logic [FW-1:0] mag_src;
  logic [FW-1:0] mag_clamped;
  logic signed [FW-1:0] next_freq;
  logic [NST-1:0] ev;
  logic warn_cond;

  // access phase: psel and penable both high
  assign access = psel && penable;

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_s1 <= '0;
      term_s2 <= '0;
      sm_s1 <= 1'b0;
      sm_s2 <= 1'b0;
    end else if (ce) begin
      term_s1 <= input_terminal_pins;
      term_s2 <= term_s1;
      sm_s1 <= second_motor_pin;
      sm_s2 <= sm_s1;
    end
  end

  // limit write decode and shadow of all four limits for range checks
  always_comb begin
    lim_set = (paddr == ADDR_UPPER2) || (paddr == ADDR_LOWER2);
    lim_upper = (paddr == ADDR_UPPER1) || (paddr == ADDR_UPPER2);
    lim_wdata = pwdata[FW-1:0];
    // range checks look at the other limit of the same set
    peer_up = lim_set ? up2_shadow : up1_shadow;
    peer_lo = lim_set ? lo2_shadow : lo1_shadow;
    // words other than limits are always accepted
    wr_ok = 1'b1;
    if (lim_upper) begin
      wr_ok = (lim_wdata == '0) ||
              (lim_wdata >= peer_lo && lim_wdata <= max_freq);
    end else begin
      wr_ok = (lim_wdata == '0) ||
              (lim_wdata >= min_freq &&
               (peer_up == '0 || lim_wdata <= peer_up));
    end
    // only in-range limit writes reach the bank
    lim_wr = access && pwrite && wr_ok &&
             (paddr == ADDR_UPPER1 || paddr == ADDR_LOWER1 ||
              paddr == ADDR_UPPER2 || paddr == ADDR_LOWER2);
  end

  // bus-visible copies of all four limits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up1_shadow <= RST_LIMIT;
      lo1_shadow <= RST_LIMIT;
      up2_shadow <= RST_LIMIT;
      lo2_shadow <= RST_LIMIT;
    end else if (ce && lim_wr) begin
      unique case (paddr)
        ADDR_UPPER1: up1_shadow <= lim_wdata;
        ADDR_LOWER1: lo1_shadow <= lim_wdata;
        ADDR_UPPER2: up2_shadow <= lim_wdata;
        default: lo2_shadow <= lim_wdata;
      endcase
    end
  end

  // limit copy selected by second motor input
  dcl_limit_bank u_bank (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr_en(lim_wr),
    .wr_set(lim_set),
    .wr_upper(lim_upper),
    .wr_data(lim_wdata),
    .rd_set(sm_s2),
    .upper(upper_frequency_limit),
    .lower(lower_frequency_limit)
  );

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_direction_restriction <= DIR_NONE;
      reversal_protection_select <= 2'h0;
      control_mode_select <= 2'h0;
      jog_frequency_setting <= '0;
      max_freq <= RST_MAXF;
      min_freq <= RST_MINF;
      mask <= '0;
    end else if (ce && access && pwrite) begin
      unique case (paddr)
        // control word: direction, protection, mode
        ADDR_CTRL: begin
          run_direction_restriction <= pwdata[CTRL_DIR_LSB +: 2];
          reversal_protection_select <= pwdata[CTRL_REV_LSB +: 2];
          control_mode_select <= pwdata[CTRL_MODE_LSB +: 2];
        end
        ADDR_JOG: jog_frequency_setting <= pwdata[FW-1:0];
        ADDR_MAXF: max_freq <= pwdata[FW-1:0];
        ADDR_MINF: min_freq <= pwdata[FW-1:0];
        ADDR_MASK: mask <= pwdata[NST-1:0];
        default: ;
      endcase
    end
  end

  // terminal function assignment, seven nibbles
  genvar gi;
  generate
    for (gi = 0; gi < NTERM; gi++) begin : g_term
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          term_fn[gi] <= '0;
        end else if (ce && access && pwrite && paddr == ADDR_TERM) begin
          // nibble value one assigns run enable
          term_fn[gi] <= 7'(pwdata[gi*4 +: 4] == 4'h1 ? FN_RUN_ENABLE : 7'h0);
        end
      end
      assign permit_hit[gi] = (term_fn[gi] == FN_RUN_ENABLE) && term_s2[gi];
    end
  endgenerate

  // run permission and direction logic
  always_comb begin
    // any terminal assigned run enable
    permit_assigned = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      permit_assigned = permit_assigned || (term_fn[i] == FN_RUN_ENABLE);
    end
    permit_on = !permit_assigned || (|permit_hit);
    want_rev = run_rev ^ (!jog_sel && base_frequency_command < 0);
    blocked = run_cmd &&
              ((run_direction_restriction == DIR_FWD && want_rev) ||
               (run_direction_restriction == DIR_REV && !want_rev));
    running = run_cmd && !blocked && permit_on;
  end

  // magnitude selection and clamping
  always_comb begin
    // jog ignores the command sign
    mag_src = jog_sel ? jog_frequency_setting :
              (base_frequency_command < 0 ?
               FW'(-base_frequency_command) :
               FW'(base_frequency_command));
    mag_clamped = mag_src;
    // clamp to nearest limit; zero disables
    if (upper_frequency_limit != '0 && mag_src > upper_frequency_limit) begin
      mag_clamped = upper_frequency_limit;
    end
    if (lower_frequency_limit != '0 && mag_src < lower_frequency_limit) begin
      mag_clamped = lower_frequency_limit;
    end
    // sign follows the requested direction
    next_freq = want_rev ? FW'(-mag_clamped) : FW'(mag_clamped);
    if (reversal_protection_select == REVP_ON &&
        control_mode_select == MODE_SLV &&
        ((rotation_estimate < 0) != want_rev) && rotation_estimate != 0) begin
      next_freq = '0;
    end
    // no run, no output
    if (!running) begin
      next_freq = '0;
    end
  end

  assign warn_cond = (up1_shadow > max_freq) || (up2_shadow > max_freq) ||
                     (up1_shadow != '0 && lo1_shadow > up1_shadow) ||
                     (up2_shadow != '0 && lo2_shadow > up2_shadow) ||
                     (lo1_shadow != '0 && lo1_shadow < min_freq) ||
                     (lo2_shadow != '0 && lo2_shadow < min_freq);

  // events that set the sticky status bits
  always_comb begin
    ev = '0;
    ev[ST_REJECT] = access && pwrite && !wr_ok &&
                    (paddr == ADDR_UPPER1 || paddr == ADDR_LOWER1 ||
                     paddr == ADDR_UPPER2 || paddr == ADDR_LOWER2);
    ev[ST_WARN] = warn_cond;
    ev[ST_BLOCK] = blocked;
    // loss while a run is requested
    ev[ST_PERMIT_LOST] = permit_d && !permit_on && run_cmd;
  end

  // sticky status, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
      permit_d <= 1'b1;
    end else if (ce) begin
      // previous permission, for the loss edge
      permit_d <= permit_on;
      if (access && pwrite && paddr == ADDR_STATUS) begin
        status <= (status & ~pwdata[NST-1:0]) | ev;
      end else begin
        status <= status | ev;
      end
    end
  end

  // motor outputs and indications
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_out <= '0;
      motor_enable <= 1'b0;
      restriction_display <= 1'b0;
      limit_warning <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      // command path, one cycle after the inputs
      freq_out <= next_freq;
      motor_enable <= running;
      restriction_display <= blocked;
      limit_warning <= warn_cond;
      // level interrupt from unmasked status
      irq <= |(status & mask);
    end
  end

  // apb read and answer, zero wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      // answer in the access cycle that follows setup
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      // read word launched at setup
      if (psel && !penable) begin
        unique case (paddr)
          ADDR_CTRL: prdata <= 32'({control_mode_select,
                                    reversal_protection_select,
                                    run_direction_restriction});
          ADDR_UPPER1: prdata <= 32'(up1_shadow);
          ADDR_LOWER1: prdata <= 32'(lo1_shadow);
          ADDR_UPPER2: prdata <= 32'(up2_shadow);
          ADDR_LOWER2: prdata <= 32'(lo2_shadow);
          ADDR_JOG: prdata <= 32'(jog_frequency_setting);
          ADDR_MAXF: prdata <= 32'(max_freq);
          ADDR_MINF: prdata <= 32'(min_freq);
          ADDR_STATUS: prdata <= 32'(status);
          ADDR_MASK: prdata <= 32'(mask);
          ADDR_OUT: prdata <= {14'h0, permit_on, sm_s2, freq_out};
          ADDR_TERM: prdata <= 32'h0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : dcl_limiter
`default_nettype wire

// ===== dcl_pkg.sv
/*
  shared constants for the drive command limiter: register offsets,
  field positions, reset values and setting codes.
  assumes a 32-bit apb slave port and frequencies in 0.01 hz units.
*/
package dcl_pkg;
  localparam int FW = 16;
  localparam int NTERM = 7;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_UPPER1 = 8'h04;
  localparam logic [7:0] ADDR_LOWER1 = 8'h08;
  localparam logic [7:0] ADDR_UPPER2 = 8'h0c;
  localparam logic [7:0] ADDR_LOWER2 = 8'h10;
  localparam logic [7:0] ADDR_JOG = 8'h14;
  localparam logic [7:0] ADDR_MAXF = 8'h18;
  localparam logic [7:0] ADDR_MINF = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_MASK = 8'h24;
  localparam logic [7:0] ADDR_OUT = 8'h28;
  localparam logic [7:0] ADDR_TERM = 8'h2c;
  // ctrl fields
  localparam int CTRL_DIR_LSB = 0;
  localparam int CTRL_REV_LSB = 2;
  localparam int CTRL_MODE_LSB = 4;
  // status bits
  localparam int ST_REJECT = 0;
  localparam int ST_WARN = 1;
  localparam int ST_BLOCK = 2;
  localparam int ST_PERMIT_LOST = 3;
  localparam int NST = 4;
  // setting codes
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_FWD = 2'h1;
  localparam logic [1:0] DIR_REV = 2'h2;
  localparam logic [1:0] REVP_ON = 2'h1;
  localparam logic [1:0] MODE_SLV = 2'h3;
  localparam logic [6:0] FN_RUN_ENABLE = 7'h54;
  // reset values
  localparam logic [FW-1:0] RST_MAXF = 16'h1770;
  localparam logic [FW-1:0] RST_MINF = 16'h0000;
  localparam logic [FW-1:0] RST_LIMIT = 16'h0000;
endpackage : dcl_pkg

// ===== tb_top.sv
/*
  bench for dcl_limiter: apb tasks and a control model on the pins.
  assumes the package offsets and a 100 mhz pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dcl_pkg::*;
;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NTERM-1:0] pins;
  logic sm_pin, run_cmd, run_rev, jog_sel, r_permit, r_m2, r_run, r_rev;
  logic r_jog, motor_enable, restriction_display, limit_warning, irq;
  logic signed [FW-1:0] cmd, est, freq_out, r_freq, r_est;
  int n_mismatch, checks_done;
  // free running clock
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  dcl_limiter i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_terminal_pins(pins), .second_motor_pin(sm_pin),
    .run_cmd(run_cmd), .run_rev(run_rev), .jog_sel(jog_sel),
    .base_frequency_command(cmd), .rotation_estimate(est),
    .freq_out(freq_out), .motor_enable(motor_enable),
    .restriction_display(restriction_display),
    .limit_warning(limit_warning), .irq(irq)
  );
  dcl_ctl_model #(.PERMIT_TERM(2)) i_ctl (
    .pclk(pclk), .presetn(presetn), .permit(r_permit), .motor2(r_m2),
    .run(r_run), .rev(r_rev), .jog(r_jog), .freq(r_freq), .est(r_est),
    .input_terminal_pins(pins), .second_motor_pin(sm_pin),
    .run_cmd(run_cmd), .run_rev(run_rev), .jog_sel(jog_sel),
    .base_frequency_command(cmd), .rotation_estimate(est)
  );
  // verdict and end of run
  task give_verdict;
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // one comparison
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  // one apb transfer, waits on pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      $display("unexpected at %0t: no pready", $time);
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask : settle
  task automatic out(input logic e, input logic [15:0] f);
    settle();
    cmp(motor_enable, e);
    cmp(freq_out, f);
  endtask : out
  // main sequence
  initial begin
    logic [3:0] k;
    logic x, e;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ce, r_run, r_permit, r_m2, r_rev, r_jog} = 6'h30;
    r_freq = 16'h2710;
    r_est = 16'h0000;
    n_mismatch = 0;
    checks_done = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(0, ADDR_MAXF, 0); cmp(rd[15:0], RST_MAXF);
    apb(0, ADDR_UPPER1, 0); cmp(rd[15:0], RST_LIMIT);
    apb(0, 8'hfc, 0);
    cmp(err, 1'h1);
    apb(0, ADDR_MINF, 0);
    cmp(err, 1'h0);
    cmp(rd[15:0], RST_MINF);
    apb(1, ADDR_UPPER1, 32'h1388);
    apb(1, ADDR_LOWER1, 32'h03e8);
    out(1, 16'h1388);
    cmp(limit_warning, 1'h0);
    r_freq <= 16'h0100;
    out(1, 16'h03e8);
    r_rev <= 1'h1;
    out(1, 16'hfc18);
    r_rev <= 1'h0;
    apb(1, ADDR_MASK, 32'h1);
    apb(1, ADDR_UPPER1, 32'h2000);
    apb(1, ADDR_LOWER1, 32'h2000);
    apb(0, ADDR_LOWER1, 0); cmp(rd[15:0], 16'h03e8);
    apb(0, ADDR_UPPER1, 0); cmp(rd[15:0], 16'h1388);
    cmp(irq, 1'h1);
    apb(1, ADDR_STATUS, 32'h1);
    apb(0, ADDR_STATUS, 0); cmp(rd[0], 1'h0);
    cmp(irq, 1'h0);
    apb(1, ADDR_JOG, 32'h1500);
    r_jog <= 1'h1;
    out(1, 16'h1388);
    {r_jog, r_m2, r_freq} <= {2'h1, 16'h2710};
    out(1, 16'h2710);
    r_freq <= 16'h0010;
    out(1, 16'h0010);
    apb(1, ADDR_UPPER2, 32'h1000);
    r_freq <= 16'h2710;
    out(1, 16'h1000);
    r_m2 <= 1'h0;
    out(1, 16'h1388);
    for (int i = 0; i < 12; i++) begin
      k = i[3:0];
      apb(1, ADDR_CTRL, {30'h0, k[3:2]});
      r_rev <= k[1];
      r_freq <= k[0] ? 16'hf800 : 16'h0800;
      settle();
      x = k[1] ^ k[0];
      e = k[3:2] == DIR_NONE || (k[3:2] == DIR_FWD) == !x;
      cmp(motor_enable, e);
      cmp(restriction_display, !e);
    end
    {r_rev, r_freq, r_est} <= {1'h0, 16'h0800, 16'hff00};
    apb(1, ADDR_CTRL, {26'h0, MODE_SLV, REVP_ON, DIR_NONE});
    out(1, 16'h0000);
    apb(1, ADDR_CTRL, {28'h0, REVP_ON, DIR_NONE});
    out(1, 16'h0800);
    ce <= 1'h0;
    r_run <= 1'h0;
    settle();
    cmp(motor_enable, 1'h1);
    ce <= 1'h1;
    settle();
    cmp(motor_enable, 1'h0);
    r_run <= 1'h1;
    apb(1, ADDR_TERM, 32'h100);
    apb(0, ADDR_TERM, 0); cmp(rd[15:0], 16'h0000);
    out(0, 16'h0000);
    r_permit <= 1'h1;
    out(1, 16'h0800);
    r_permit <= 1'h0;
    settle();
    cmp(motor_enable, 1'h0);
    apb(0, ADDR_STATUS, 0);
    cmp(rd[ST_PERMIT_LOST], 1'h1);
    cmp(rd[ST_BLOCK], 1'h1);
    apb(1, ADDR_MAXF, 32'h1000);
    settle();
    cmp(limit_warning, 1'h1);
    apb(0, ADDR_STATUS, 0);
    cmp(rd[ST_WARN], 1'h1);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
